// File: design/scr_pkg.sv
package scr_pkg;

    localparam int WORD_W   = 32;
    localparam int CODE_W   = 4;
    localparam int INT_W    = 16;
    localparam int MAIN_FRACTION_NUMERATOR_W  = 24;
    localparam int AUX_W    = 14;
    localparam int PHASE_W  = 24;
    localparam int MUX_W    = 3;
    localparam int RCNT_W   = 10;
    localparam int CP_W     = 4;
    localparam int DIVSEL_W = 3;

    // Register select codes carried in the low bits of every word.
    localparam logic [CODE_W-1:0] SEL_INT   = 4'h0;
    localparam logic [CODE_W-1:0] SEL_FRAC  = 4'h1;
    localparam logic [CODE_W-1:0] SEL_AUX   = 4'h2;
    localparam logic [CODE_W-1:0] SEL_PHASE = 4'h3;
    localparam logic [CODE_W-1:0] SEL_REF   = 4'h4;

    // Word 0 layout.
    localparam int INT_LSB     = 4;
    localparam int PRESC_BIT   = 20;
    localparam int AUTOCAL_BIT = 21;
    // Word 1 layout.
    localparam int MAIN_FRACTION_NUMERATOR_LSB   = 4;
    // Word 2 layout.
    localparam int AUXM_LSB    = 4;
    localparam int AUXN_LSB    = 18;
    // Word 3 layout.
    localparam int PHASE_LSB   = 4;
    localparam int ADJ_BIT     = 28;
    localparam int RESYNC_BIT  = 29;
    localparam int SUPP_BIT    = 30;
    // Word 4 layout.
    localparam int CRST_BIT    = 4;
    localparam int TRI_BIT     = 5;
    localparam int PD_BIT      = 6;
    localparam int POL_BIT     = 7;
    localparam int LVL_BIT     = 8;
    localparam int REFMODE_BIT = 9;
    localparam int CP_LSB      = 10;
    localparam int BUFEN_BIT   = 14;
    localparam int RCNT_LSB    = 15;
    localparam int HALVE_BIT   = 25;
    localparam int DBL_BIT     = 26;
    localparam int MUX_LSB     = 27;

    localparam logic [RCNT_W-1:0] RST_RCOUNT = 10'h001;

    typedef struct packed {
        logic [INT_W-1:0]   int_value;
        logic               prescaler_or_resync_select;
        logic [MAIN_FRACTION_NUMERATOR_W-1:0] main_fraction_numerator;
        logic [AUX_W-1:0]   aux_fraction_numerator;
        logic [AUX_W-1:0]   aux_fraction_modulus;
        logic [PHASE_W-1:0] phase_value;
        logic               modulator_reset_suppress;
        logic               phase_resync_enable;
        logic               phase_adjust_enable;
        logic [MUX_W-1:0]   test_output_selector;
        logic               reference_doubler_enable;
        logic               reference_halve_enable;
        logic [RCNT_W-1:0]  ref_count;
        logic               divider_select_buffer_enable;
        logic [CP_W-1:0]    pump_current_code;
        logic               ref_differential;
        logic               output_logic_level_select;
        logic               detector_polarity_select;
        logic               soft_power_down;
        logic               pump_tristate;
        logic               divider_counters_reset;
    } scr_cfg_t;

endpackage

// File: design/scr_ref_divider.sv
`timescale 1ns/1ps
module scr_ref_divider #(
    parameter int RW = 10
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          reference_input,
    input  wire logic          doubler,
    input  wire logic          halve,
    input  wire logic [RW-1:0] ratio,
    input  wire logic          hold,
    output logic               pfd_ref_r
);

    logic [2:0]    ref_q;
    logic [RW-1:0] cnt_r;
    logic [RW-1:0] cnt_nxt;
    logic          tog_r;
    logic          tog_nxt;
    logic          pfd_nxt;
    logic          rise;
    logic          fall;
    logic          active;
    logic [RW:0]   ratio_eff;

    assign rise = ref_q[1] & ~ref_q[2];
    assign fall = ~ref_q[1] & ref_q[2];

    always_comb
    begin
        // A ratio of zero is not a legal setting; treat it as one.
        ratio_eff = (ratio == '0) ? (RW+1)'(1) : {1'b0, ratio};
        active    = doubler ? (rise | fall) : fall;
        cnt_nxt   = cnt_r;
        tog_nxt   = tog_r;
        pfd_nxt   = 1'b0;
        if (hold)
        begin
            cnt_nxt = '0;
            tog_nxt = 1'b0;
        end
        else if (active)
        begin
            if ({1'b0, cnt_r} + (RW+1)'(1) >= ratio_eff)
            begin
                cnt_nxt = '0;
                tog_nxt = ~tog_r;
                pfd_nxt = ~halve;
            end
            else
            begin
                cnt_nxt = cnt_r + RW'(1);
            end
        end
        if (halve && !hold)
        begin
            pfd_nxt = tog_nxt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ref_q     <= '0;
            cnt_r     <= '0;
            tog_r     <= 1'b0;
            pfd_ref_r <= 1'b0;
        end
        else
        begin
            ref_q     <= {ref_q[1:0], reference_input};
            cnt_r     <= cnt_nxt;
            tog_r     <= tog_nxt;
            pfd_ref_r <= pfd_nxt;
        end
    end

    property p_hold_quiet;
        @(posedge clk) disable iff (!rst_n)
        hold |=> !pfd_ref_r && cnt_r == '0;
    endproperty
    a_hold_quiet: assert property (p_hold_quiet)
        else $error("reference divider not held");

endmodule

// File: design/scr_regs.sv
`timescale 1ns/1ps
module scr_regs (
    input  wire logic                            clk,
    input  wire logic                            rst_n,
    input  wire logic                            serial_clock,
    input  wire logic                            serial_data,
    input  wire logic                            load_enable,
    input  wire logic                            reference_input,
    input  wire logic [scr_pkg::DIVSEL_W-1:0]    div_select_in,
    output scr_pkg::scr_cfg_t                    cfg_r,
    output logic [scr_pkg::PHASE_W-1:0]          phase_acc_r,
    output logic                                 autocal_start_r,
    output logic                                 modulator_reset_r,
    output logic [scr_pkg::DIVSEL_W-1:0]         div_select_r,
    output logic                                 pump_off_r,
    output logic                                 counters_hold_r,
    output logic                                 outputs_off_r,
    output logic                                 pfd_ref_r
);

    logic [2:0]                       sclk_q;
    logic [1:0]                       sdat_q;
    logic [2:0]                       le_q;
    logic [scr_pkg::WORD_W-1:0]       shift_r;
    logic [scr_pkg::WORD_W-1:0]       shift_nxt;
    logic                             load;
    logic [scr_pkg::CODE_W-1:0]       code;
    scr_pkg::scr_cfg_t                cfg_nxt;
    scr_pkg::scr_cfg_t                stg_r;
    scr_pkg::scr_cfg_t                stg_nxt;
    logic [scr_pkg::PHASE_W-1:0]      phase_nxt;
    logic                             cal_nxt;
    logic                             sdr_nxt;
    logic [scr_pkg::DIVSEL_W-1:0]     div_nxt;
    logic [scr_pkg::MAIN_FRACTION_NUMERATOR_W-1:0]      w_main_fraction_numerator;
    logic [scr_pkg::AUX_W-1:0]        w_auxm;
    logic [scr_pkg::MAIN_FRACTION_NUMERATOR_W-1:0]      stg_main_fraction_numerator;
    logic [scr_pkg::MAIN_FRACTION_NUMERATOR_W-1:0]      act_main_fraction_numerator;
    logic [scr_pkg::PHASE_W-1:0]      stg_phase;
    logic                             w_autocal;
    logic                             w_presc;
    logic                             supp;
    logic                             w0_load;

    assign load      = le_q[1] & ~le_q[2];
    assign code      = shift_r[scr_pkg::CODE_W-1:0];
    assign w_main_fraction_numerator   = shift_r[scr_pkg::MAIN_FRACTION_NUMERATOR_LSB +: scr_pkg::MAIN_FRACTION_NUMERATOR_W];
    assign w_auxm    = shift_r[scr_pkg::AUXM_LSB +: scr_pkg::AUX_W];
    assign w_autocal = shift_r[scr_pkg::AUTOCAL_BIT];
    assign w_presc   = shift_r[scr_pkg::PRESC_BIT];
    assign stg_main_fraction_numerator = stg_r.main_fraction_numerator;
    assign act_main_fraction_numerator = cfg_r.main_fraction_numerator;
    assign stg_phase = stg_r.phase_value;
    assign supp      = cfg_r.modulator_reset_suppress;
    assign w0_load   = load && code == scr_pkg::SEL_INT;

    // Serial pins are asynchronous; each level must last at least one clk period.
    always_comb
    begin
        shift_nxt = shift_r;
        if (sclk_q[1] && !sclk_q[2])
            shift_nxt = {shift_r[scr_pkg::WORD_W-2:0], sdat_q[1]};
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sclk_q  <= '0;
            sdat_q  <= '0;
            le_q    <= '0;
            shift_r <= '0;
        end
        else
        begin
            sclk_q  <= {sclk_q[1:0], serial_clock};
            sdat_q  <= {sdat_q[0], serial_data};
            le_q    <= {le_q[1:0], load_enable};
            shift_r <= shift_nxt;
        end
    end

    always_comb
    begin
        cfg_nxt   = cfg_r;
        stg_nxt   = stg_r;
        phase_nxt = phase_acc_r;
        cal_nxt   = 1'b0;
        sdr_nxt   = 1'b0;
        div_nxt   = cfg_r.divider_select_buffer_enable ? div_select_r
                                                       : div_select_in;
        if (load)
        begin
            unique case (code)
                scr_pkg::SEL_INT:
                begin
                    cfg_nxt.int_value =
                        shift_r[scr_pkg::INT_LSB +: scr_pkg::INT_W];
                    cfg_nxt.prescaler_or_resync_select = w_presc;
                    // Staged fields apply together as one step.
                    cfg_nxt.main_fraction_numerator = stg_main_fraction_numerator;
                    cfg_nxt.aux_fraction_numerator =
                        stg_r.aux_fraction_numerator;
                    cfg_nxt.aux_fraction_modulus = stg_r.aux_fraction_modulus;
                    cfg_nxt.phase_value = stg_phase;
                    cfg_nxt.reference_doubler_enable =
                        stg_r.reference_doubler_enable;
                    cfg_nxt.reference_halve_enable =
                        stg_r.reference_halve_enable;
                    cfg_nxt.ref_count = stg_r.ref_count;
                    cfg_nxt.pump_current_code = stg_r.pump_current_code;
                    cal_nxt = w_autocal;
                    sdr_nxt = ~supp;
                    if (cfg_r.phase_adjust_enable)
                        phase_nxt = phase_acc_r + stg_phase;
                    div_nxt = div_select_in;
                end
                scr_pkg::SEL_FRAC:
                    stg_nxt.main_fraction_numerator = w_main_fraction_numerator;
                scr_pkg::SEL_AUX:
                begin
                    stg_nxt.aux_fraction_numerator =
                        shift_r[scr_pkg::AUXN_LSB +: scr_pkg::AUX_W];
                    stg_nxt.aux_fraction_modulus = w_auxm;
                end
                scr_pkg::SEL_PHASE:
                begin
                    stg_nxt.phase_value =
                        shift_r[scr_pkg::PHASE_LSB +: scr_pkg::PHASE_W];
                    cfg_nxt.modulator_reset_suppress =
                        shift_r[scr_pkg::SUPP_BIT];
                    cfg_nxt.phase_resync_enable = shift_r[scr_pkg::RESYNC_BIT];
                    cfg_nxt.phase_adjust_enable = shift_r[scr_pkg::ADJ_BIT];
                end
                scr_pkg::SEL_REF:
                begin
                    cfg_nxt.test_output_selector =
                        shift_r[scr_pkg::MUX_LSB +: scr_pkg::MUX_W];
                    stg_nxt.reference_doubler_enable =
                        shift_r[scr_pkg::DBL_BIT];
                    stg_nxt.reference_halve_enable =
                        shift_r[scr_pkg::HALVE_BIT];
                    stg_nxt.ref_count =
                        shift_r[scr_pkg::RCNT_LSB +: scr_pkg::RCNT_W];
                    cfg_nxt.divider_select_buffer_enable =
                        shift_r[scr_pkg::BUFEN_BIT];
                    stg_nxt.pump_current_code =
                        shift_r[scr_pkg::CP_LSB +: scr_pkg::CP_W];
                    cfg_nxt.ref_differential =
                        shift_r[scr_pkg::REFMODE_BIT];
                    cfg_nxt.output_logic_level_select =
                        shift_r[scr_pkg::LVL_BIT];
                    cfg_nxt.detector_polarity_select =
                        shift_r[scr_pkg::POL_BIT];
                    cfg_nxt.soft_power_down =
                        shift_r[scr_pkg::PD_BIT];
                    cfg_nxt.pump_tristate = shift_r[scr_pkg::TRI_BIT];
                    cfg_nxt.divider_counters_reset =
                        shift_r[scr_pkg::CRST_BIT];
                end
                default: ; // Codes of other registers are ignored.
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cfg_r             <= '0;
            cfg_r.ref_count   <= scr_pkg::RST_RCOUNT;
            stg_r             <= '0;
            stg_r.ref_count   <= scr_pkg::RST_RCOUNT;
            phase_acc_r       <= '0;
            autocal_start_r   <= 1'b0;
            modulator_reset_r <= 1'b0;
            div_select_r      <= '0;
            pump_off_r        <= 1'b0;
            counters_hold_r   <= 1'b0;
            outputs_off_r     <= 1'b0;
        end
        else
        begin
            cfg_r             <= cfg_nxt;
            stg_r             <= stg_nxt;
            phase_acc_r       <= phase_nxt;
            autocal_start_r   <= cal_nxt;
            modulator_reset_r <= sdr_nxt;
            div_select_r      <= div_nxt;
            // Power down overrides pump and counters; settings are kept.
            pump_off_r      <= cfg_r.pump_tristate | cfg_r.soft_power_down;
            counters_hold_r <= cfg_r.divider_counters_reset
                               | cfg_r.soft_power_down;
            outputs_off_r   <= cfg_r.soft_power_down;
        end
    end

    scr_ref_divider #(.RW(scr_pkg::RCNT_W)) u_ref_div (
        .clk             (clk),
        .rst_n           (rst_n),
        .reference_input (reference_input),
        .doubler         (cfg_r.reference_doubler_enable),
        .halve           (cfg_r.reference_halve_enable),
        .ratio           (cfg_r.ref_count),
        .hold            (counters_hold_r),
        .pfd_ref_r       (pfd_ref_r)
    );

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_frac_route;
        load && code == scr_pkg::SEL_FRAC
            |=> stg_main_fraction_numerator == $past(w_main_fraction_numerator) && $stable(act_main_fraction_numerator);
    endproperty
    a_frac_route: assert property (p_frac_route)
        else $error("word 1 not staged");
    property p_autocal;
        w0_load |=> autocal_start_r == $past(w_autocal) ##1 !autocal_start_r;
    endproperty
    a_autocal: assert property (p_autocal)
        else $error("calibration start wrong");
    property p_presc;
        w0_load |=> cfg_r.prescaler_or_resync_select == $past(w_presc);
    endproperty
    a_presc: assert property (p_presc)
        else $error("prescaler select not taken");
    property p_aux_mod;
        load && code == scr_pkg::SEL_AUX
            |=> stg_r.aux_fraction_modulus == $past(w_auxm);
    endproperty
    a_aux_mod: assert property (p_aux_mod)
        else $error("aux modulus not staged");
    property p_sd_reset;
        w0_load |=> modulator_reset_r == !$past(supp);
    endproperty
    a_sd_reset: assert property (p_sd_reset)
        else $error("modulator reset wrong");
    property p_phase_step;
        w0_load && cfg_r.phase_adjust_enable
            |=> phase_acc_r == $past(phase_acc_r) + $past(stg_phase);
    endproperty
    a_phase_step: assert property (p_phase_step)
        else $error("phase not advanced");
    property p_transfer;
        w0_load |=> act_main_fraction_numerator == $past(stg_main_fraction_numerator);
    endproperty
    a_transfer: assert property (p_transfer)
        else $error("staged fraction not applied");
    property p_divsel_hold;
        cfg_r.divider_select_buffer_enable && !w0_load
            |=> $stable(div_select_r);
    endproperty
    a_divsel_hold: assert property (p_divsel_hold)
        else $error("divider select changed early");
    property p_power_down;
        cfg_r.soft_power_down |=> pump_off_r && counters_hold_r ##1 !pfd_ref_r;
    endproperty
    a_power_down: assert property (p_power_down)
        else $error("power down incomplete");
    property p_tristate;
        cfg_r.pump_tristate |=> pump_off_r;
    endproperty
    a_tristate: assert property (p_tristate)
        else $error("pump not floated");

    c_cal: cover property (autocal_start_r);
    c_adjust: cover property (w0_load && cfg_r.phase_adjust_enable);
    c_ref_write: cover property (load && code == scr_pkg::SEL_REF);
endmodule

// File: dv/scr_host.sv
`timescale 1ns/1ps
module scr_host (
    input  wire logic clk,
    output logic      serial_clock,
    output logic      serial_data,
    output logic      load_enable
);
    initial
    begin
        serial_clock = 1'b0;
        serial_data  = 1'b0;
        load_enable  = 1'b0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Reserved bits go out as zeros whatever the caller passes.
    function automatic logic [31:0] clean(input logic [31:0] w);
        case (w[3:0])
            4'h0:    clean = w & 32'h003f_ffff;
            4'h1:    clean = w & 32'h0fff_ffff;
            4'h3:    clean = w & 32'h7fff_ffff;
            4'h4:    clean = w & 32'h3fff_ffff;
            default: clean = w;
        endcase
    endfunction
    // Every pin level lasts at least hold cycles, since the synchronisers in the
    // block can lose anything shorter than one clock period.
    task automatic send(input logic [31:0] word, input int hold);
        logic [31:0] w;
        w = clean(word);
        for (int i = 31; i >= 0; i--)
        begin
            serial_data = w[i];
            step(hold);
            serial_clock = 1'b1;
            step(hold);
            serial_clock = 1'b0;
        end
        // The released data line must not keep showing the last bit.
        serial_data = ~w[0];
        step(hold);
        load_enable = 1'b1;
        step(2 * hold);
        load_enable = 1'b0;
        step(hold);
    endtask
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    localparam int LIMIT = 20000;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              reference_input = 1'b0;
    logic [2:0]        div_select_in = 3'h0;
    logic              serial_clock;
    logic              serial_data;
    logic              load_enable;
    scr_pkg::scr_cfg_t cfg_r;
    scr_pkg::scr_cfg_t e;
    logic [23:0]       phase_acc_r;
    logic              autocal_start_r;
    logic              modulator_reset_r;
    logic [2:0]        div_select_r;
    logic              pump_off_r;
    logic              counters_hold_r;
    logic              outputs_off_r;
    logic              pfd_ref_r;
    logic              pfd_q = 1'b0;
    int                n_mismatch = 0;
    int                checked = 0;
    int                n_cal = 0;
    int                n_mrst = 0;
    int                n_rise = 0;
    int                cyc = 0;
    int                last_rise = 0;
    int                last_gap = 0;
    scr_regs u_scr_regs (
        .clk(clk),
        .rst_n(rst_n),
        .serial_clock(serial_clock),
        .serial_data(serial_data),
        .load_enable(load_enable),
        .reference_input(reference_input),
        .div_select_in(div_select_in),
        .cfg_r(cfg_r),
        .phase_acc_r(phase_acc_r),
        .autocal_start_r(autocal_start_r),
        .modulator_reset_r(modulator_reset_r),
        .div_select_r(div_select_r),
        .pump_off_r(pump_off_r),
        .counters_hold_r(counters_hold_r),
        .outputs_off_r(outputs_off_r),
        .pfd_ref_r(pfd_ref_r)
    );
    scr_host u_scr_host (
        .clk(clk),
        .serial_clock(serial_clock),
        .serial_data(serial_data),
        .load_enable(load_enable)
    );
    always #10 clk = ~clk;
    // Reference period is eight clocks, so active edges are easy to count.
    always
    begin
        repeat (4) @(posedge clk);
        #1 reference_input = ~reference_input;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        pfd_q <= pfd_ref_r;
        if (autocal_start_r === 1'b1)
            n_cal <= n_cal + 1;
        if (modulator_reset_r === 1'b1)
            n_mrst <= n_mrst + 1;
        if (pfd_ref_r === 1'b1 && pfd_q === 1'b0)
        begin
            n_rise <= n_rise + 1;
            last_rise <= cyc;
            last_gap <= cyc - last_rise;
        end
        if (cyc == LIMIT)
        begin
            n_mismatch = n_mismatch + 1;
            wrap_up();
        end
    end
    task automatic check(input logic [127:0] s, input logic [127:0] x);
        checked++;
        if (s !== x)
        begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic chk_cfg;
        check(128'(cfg_r), 128'(e));
    endtask
    function automatic logic [2:0] offs();
        offs = {pump_off_r, counters_hold_r, outputs_off_r};
    endfunction
    task automatic put(input logic [31:0] w);
        u_scr_host.send(w, 4);
    endtask
    function automatic logic [31:0] w0(input logic c, input logic p,
                                       input logic [15:0] n);
        w0 = {10'h000, c, p, n, scr_pkg::SEL_INT};
    endfunction
    // Polarity stays one and the pump current code fixed.
    // The multiplexer stays on one code, kept off the dividers.
    function automatic logic [31:0] w4(input logic d, input logic h,
        input logic [9:0] r, input logic b, input logic [2:0] u);
        w4 = {5'h05, d, h, r, b, 4'h2, 3'h7, u, scr_pkg::SEL_REF};
    endfunction
    task automatic t_word0;
        int c0;
        int m0;
        c0 = n_cal;
        m0 = n_mrst;
        chk_cfg();
        check(128'(phase_acc_r), 128'h0);
        put(w0(1'b1, 1'b1, 16'h004b));
        e.int_value = 16'h004b;
        e.prescaler_or_resync_select = 1'b1;
        chk_cfg();
        check(128'(n_cal - c0), 128'h1);
        check(128'(n_mrst - m0), 128'h1);
        u_scr_host.send(w0(1'b0, 1'b0, 16'h7fff), 7);
        e.int_value = 16'h7fff;
        e.prescaler_or_resync_select = 1'b0;
        chk_cfg();
        check(128'(n_cal - c0), 128'h1);
        check(128'(n_mrst - m0), 128'h2);
        for (int c = 5; c < 16; c++)
            put({28'h5a5a5a5, 4'(c)});
        chk_cfg();
        check(128'(n_mrst - m0), 128'h2);
    endtask
    task automatic t_buffered;
        put({4'h0, 24'habcdef, scr_pkg::SEL_FRAC});
        put({14'h0005, 14'h2abc, scr_pkg::SEL_AUX});
        chk_cfg();
        put(w0(1'b0, 1'b0, 16'h0020));
        e.int_value = 16'h0020;
        e.main_fraction_numerator = 24'habcdef;
        e.aux_fraction_numerator = 14'h0005;
        e.aux_fraction_modulus = 14'h2abc;
        chk_cfg();
    endtask
    task automatic t_phase;
        int m0;
        put({4'b0101, 24'h900000, scr_pkg::SEL_PHASE});
        e.modulator_reset_suppress = 1'b1;
        e.phase_adjust_enable = 1'b1;
        chk_cfg();
        m0 = n_mrst;
        repeat (2) put(w0(1'b0, 1'b0, 16'h0020));
        e.phase_value = 24'h900000;
        chk_cfg();
        // Two advances of the staged value wrap past the full circle.
        check(128'(phase_acc_r), 128'h200000);
        check(128'(n_mrst - m0), 128'h0);
        // Resync wants the auxiliary numerator at zero from here on.
        put({14'h0000, 14'h2abc, scr_pkg::SEL_AUX});
        put({4'b0010, 24'h000000, scr_pkg::SEL_PHASE});
        e.modulator_reset_suppress = 1'b0;
        e.phase_adjust_enable = 1'b0;
        e.phase_resync_enable = 1'b1;
        chk_cfg();
    endtask
    task automatic t_reg4;
        int k;
        put(w4(1'b1, 1'b1, 10'h003, 1'b1, 3'b010));
        e.test_output_selector = 3'h5;
        e.divider_select_buffer_enable = 1'b1;
        e.ref_differential = 1'b1;
        e.output_logic_level_select = 1'b1;
        e.detector_polarity_select = 1'b1;
        e.pump_tristate = 1'b1;
        chk_cfg();
        check(128'(offs()), 128'h4);
        // Register 6 logic is taken as set to divided feedback.
        div_select_in = 3'h6;
        repeat (4) @(posedge clk);
        #1 check(128'(div_select_r), 128'h0);
        put(w0(1'b0, 1'b0, 16'h0020));
        e.reference_doubler_enable = 1'b1;
        e.reference_halve_enable = 1'b1;
        e.ref_count = 10'h003;
        e.pump_current_code = 4'h2;
        e.phase_value = 24'h000000;
        e.aux_fraction_numerator = 14'h0000;
        chk_cfg();
        check(128'(div_select_r), 128'h6);
        put(w4(1'b1, 1'b1, 10'h003, 1'b0, 3'b000));
        div_select_in = 3'h3;
        repeat (4) @(posedge clk);
        #1 check(128'(div_select_r), 128'h3);
        put(w4(1'b1, 1'b1, 10'h003, 1'b0, 3'b100));
        check(128'(offs()), 128'h7);
        put(w4(1'b1, 1'b1, 10'h003, 1'b0, 3'b001));
        check(128'(offs()), 128'h2);
        k = n_rise;
        repeat (100) @(posedge clk);
        #1 check(128'({n_rise - k, pfd_ref_r}), 128'h0);
    endtask
    task automatic t_ref;
        logic       d;
        logic       h;
        logic [9:0] r;
        int         x;
        for (int i = 0; i < 4; i++)
        begin
            d = (i == 1);
            h = (i == 2);
            r = (i == 3) ? 10'h001 : 10'h003;
            put(w4(d, h, r, 1'b0, 3'b000));
            put(w0(1'b0, 1'b0, 16'h0020));
            x = (8 * int'(r) >> d) << h;
            repeat (150) @(posedge clk);
            #1 check(128'(last_gap), 128'(x));
        end
    endtask
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        e = '0;
        e.ref_count = scr_pkg::RST_RCOUNT;
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        t_word0();
        t_buffered();
        t_phase();
        t_reg4();
        t_ref();
        wrap_up();
    end
endmodule
